/* rtl/fspc_pkg.sv */
// shared constants, types and states of the flash self-programming controller
package fspc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OP_TIME_US    = 2000;
  localparam int OP_CYCLES     = (OP_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int SETUP_CYCLES  = 2;
  // ==========================================================
  // unlock keys, geometry, reset values
  localparam logic [7:0]  UNLOCK_KEY1  = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY2  = 8'haa;
  localparam logic [13:0] ERASED_WORD  = 14'h3fff;
  localparam int          ROW_WORDS    = 32;
  localparam int          BLOCK_WORDS  = 4;
  localparam int          FLASH_DEPTH  = 2048;
  localparam logic [10:0] PROT_LIM_LOW = 11'h200;
  localparam logic [10:0] PROT_LIM_MID = 11'h400;
  localparam logic [7:0]  ADDR_RESET   = 8'h00;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  // ==========================================================
  // mem_control_reg bit positions
  localparam int CTL_PGD_BIT  = 7;
  localparam int CTL_FREE_BIT = 4;
  localparam int CTL_ERR_BIT  = 3;
  localparam int CTL_WRITE_ENABLE_BIT = 2;
  localparam int CTL_GO_BIT   = 1;
  localparam int CTL_RD_BIT   = 0;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic       addr_lo_we;
    logic       addr_hi_we;
    logic       data_lo_we;
    logic       data_hi_we;
    logic       ctrl_we;
    logic       unlock_we;
    logic [7:0] wdata;
  } fspc_cpu_wr_type;
  typedef struct packed {
    logic stall;
    logic ignore;
  } fspc_core_ctl_type;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_PRE, ST_BUSY} fspc_state_type;
endpackage : fspc_pkg

/* rtl/fspc_ctrl.sv */
// flash self-programming controller: read, row erase, four-word block write
// Operation
// [RULE_01] flash read uses second instruction slot
// [RULE_02] read word held until next read/overwrite
// [RULE_03] erase always clears 32-word row
// [RULE_04] upper 11 address bits pick row; the code picks the row with the upper 6 bits, widx[10:5]
// [RULE_05] erase needs select, enable, erase bits
// [RULE_06] software writes 55h then aah first
// [RULE_07] erase setup takes two ignored cycles
// [RULE_08] core stalls 2 ms, then resumes
// [RULE_09] protected segment writes are refused
// [RULE_10] writes are aligned four-word blocks
// [RULE_11] software erases before writing
// [RULE_12] four 14-bit buffers, low two bits
// [RULE_13] software sets bits, address, data, unlocks
// [RULE_14] software writes words in address order
// [RULE_15] short write fills buffer, go clears
// [RULE_16] long write: run, ignore, stall
// [RULE_17] buffers return to 3fff after write
// [RULE_18] no bulk erase from this controller
// [RULE_19] go needs unlock keys immediately before
// [RULE_20] go blocked while write enable clear
// [RULE_21] erased row reads back all ones
`timescale 1ns/100ps
module fspc_ctrl #(
  parameter int OP_CYCLES = fspc_pkg::OP_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire fspc_pkg::fspc_cpu_wr_type   cpu_wr,
  input  wire logic [1:0]                  write_protect_cfg,
  output logic [7:0]                       addr_low_reg,
  output logic [7:0]                       addr_high_reg,
  output logic [7:0]                       data_low_reg,
  output logic [5:0]                       data_high_reg,
  output logic [7:0]                       mem_control_reg,
  output fspc_pkg::fspc_core_ctl_type      core_ctl
);
  localparam int CNT_W = $clog2(OP_CYCLES + 1);

  fspc_pkg::fspc_state_type state_ff;
  logic [7:0]        addr_lo_ff;
  logic [7:0]        addr_hi_ff;
  logic [7:0]        dat_lo_ff;
  logic [5:0]        dat_hi_ff;
  logic              pgd_ff;
  logic              free_ff;
  logic              write_enable_ff;
  logic              go_ff;
  logic              rd_ff;
  logic              err_ff;
  logic              is_erase_ff;
  logic [1:0]        key_ff;
  logic [1:0]        pre_cnt_ff;
  logic [CNT_W-1:0]  busy_cnt_ff;
  logic [13:0]       buf_ff [fspc_pkg::BLOCK_WORDS];
  logic [13:0]       mem [fspc_pkg::FLASH_DEPTH];
  logic [10:0]       widx;
  logic [7:0]        wd;
  logic              go_req;
  logic              rd_req;
  logic              prot;
  logic              start_op;
  logic              go_short;
  logic              op_done;
  logic              rd_slot;

  // ==========================================================
  // decode
  function automatic logic is_protected(input logic [1:0] cfg, input logic [10:0] a);
    logic r;
    r = 1'b1;
    case (cfg)
      2'b11:   r = 1'b0;
      2'b10:   r = (a < fspc_pkg::PROT_LIM_LOW);
      2'b01:   r = (a < fspc_pkg::PROT_LIM_MID);
      default: r = 1'b1;
    endcase
    return r;
  endfunction : is_protected

  assign wd   = cpu_wr.wdata;
  assign widx = {addr_hi_ff[2:0], addr_lo_ff};
  assign prot = is_protected(write_protect_cfg, widx);
  // [RULE_01] program-side read only
  assign rd_req = cpu_wr.ctrl_we && wd[fspc_pkg::CTL_RD_BIT] && wd[fspc_pkg::CTL_PGD_BIT]
                  && state_ff == fspc_pkg::ST_IDLE;
  // [RULE_19] [RULE_20] keys and enable gate go
  assign go_req = cpu_wr.ctrl_we && wd[fspc_pkg::CTL_GO_BIT] && wd[fspc_pkg::CTL_WRITE_ENABLE_BIT]
                  && wd[fspc_pkg::CTL_PGD_BIT] && key_ff == 2'd2 && !go_ff
                  && state_ff == fspc_pkg::ST_IDLE;
  // [RULE_05] erase needs select, enable and erase bits
  assign go_short = go_req && !wd[fspc_pkg::CTL_FREE_BIT] && addr_lo_ff[1:0] != 2'b11;
  // [RULE_09] protected targets never start an operation
  assign start_op = go_req && !go_short && !prot;
  assign op_done  = state_ff == fspc_pkg::ST_BUSY && busy_cnt_ff == CNT_W'(OP_CYCLES - 1);
  // [RULE_01] the first slot after the rd write still runs; the second is taken
  // by the array, so the core must not count on anything issued in it
  assign rd_slot  = state_ff == fspc_pkg::ST_RD && pre_cnt_ff == 2'd1;

  // ==========================================================
  // unlock key tracker: any other write breaks the sequence
  // [RULE_19] keys must directly precede go
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_ff <= 2'd0;
    end else if (cpu_wr.unlock_we) begin
      if (wd == fspc_pkg::UNLOCK_KEY1) begin
        key_ff <= 2'd1;
      end else if (wd == fspc_pkg::UNLOCK_KEY2 && key_ff == 2'd1) begin
        key_ff <= 2'd2;
      end else begin
        key_ff <= 2'd0;
      end
    end else if (cpu_wr.ctrl_we || cpu_wr.addr_lo_we || cpu_wr.addr_hi_we
                 || cpu_wr.data_lo_we || cpu_wr.data_hi_we) begin
      key_ff <= 2'd0;
    end
  end

  // ==========================================================
  // address registers, software owned
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_lo_ff <= fspc_pkg::ADDR_RESET;
      addr_hi_ff <= fspc_pkg::ADDR_RESET;
    end else begin
      if (cpu_wr.addr_lo_we) addr_lo_ff <= wd;
      if (cpu_wr.addr_hi_we) addr_hi_ff <= wd;
    end
  end

  // ==========================================================
  // data registers: a finished read wins over a software write
  // [RULE_02] load on read completion, else hold
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dat_lo_ff <= fspc_pkg::DATA_RESET;
      dat_hi_ff <= 6'h00;
    end else if (rd_slot) begin
      dat_lo_ff <= mem[widx][7:0];
      dat_hi_ff <= mem[widx][13:8];
    end else begin
      if (cpu_wr.data_lo_we) dat_lo_ff <= wd;
      if (cpu_wr.data_hi_we) dat_hi_ff <= wd[5:0];
    end
  end

  // ==========================================================
  // control bits; go and rd are cleared only by hardware
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pgd_ff  <= 1'b0;
      free_ff <= 1'b0;
      write_enable_ff <= 1'b0;
      go_ff   <= 1'b0;
      rd_ff   <= 1'b0;
      err_ff  <= 1'b0;
    end else begin
      if (cpu_wr.ctrl_we) begin
        pgd_ff  <= wd[fspc_pkg::CTL_PGD_BIT];
        free_ff <= wd[fspc_pkg::CTL_FREE_BIT];
        write_enable_ff <= wd[fspc_pkg::CTL_WRITE_ENABLE_BIT];
        err_ff  <= wd[fspc_pkg::CTL_ERR_BIT] & err_ff;
      end
      if (rd_req) rd_ff <= 1'b1;
      else if (rd_slot) rd_ff <= 1'b0;
      // [RULE_15] short write clears go after one cycle
      if (go_req && !go_short && prot) begin
        err_ff <= 1'b1;
      end else if (go_req) begin
        go_ff <= 1'b1;
      end else if (go_ff && (state_ff == fspc_pkg::ST_IDLE || op_done)) begin
        go_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sequencer: read slot, setup slots, stall timer
  // [RULE_07] [RULE_16] setup then stall
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= fspc_pkg::ST_IDLE;
      is_erase_ff <= 1'b0;
      pre_cnt_ff  <= 2'd0;
      busy_cnt_ff <= '0;
    end else begin
      case (state_ff)
        fspc_pkg::ST_IDLE: begin
          pre_cnt_ff  <= 2'd0;
          busy_cnt_ff <= '0;
          if (rd_req) begin
            state_ff <= fspc_pkg::ST_RD;
          end else if (start_op) begin
            state_ff    <= fspc_pkg::ST_PRE;
            is_erase_ff <= wd[fspc_pkg::CTL_FREE_BIT];
          end
        end
        // [RULE_01] one slot passes, the second one reads the array
        fspc_pkg::ST_RD: begin
          pre_cnt_ff <= pre_cnt_ff + 2'd1;
          if (rd_slot) state_ff <= fspc_pkg::ST_IDLE;
        end
        fspc_pkg::ST_PRE: begin
          pre_cnt_ff <= pre_cnt_ff + 2'd1;
          if (pre_cnt_ff == 2'(fspc_pkg::SETUP_CYCLES - 1)) state_ff <= fspc_pkg::ST_BUSY;
        end
        // [RULE_08] stall for the full operation time
        fspc_pkg::ST_BUSY: begin
          busy_cnt_ff <= busy_cnt_ff + CNT_W'(1);
          if (op_done) state_ff <= fspc_pkg::ST_IDLE;
        end
        default: state_ff <= fspc_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // holding buffers, addressed by the low two address bits
  // [RULE_12] [RULE_17] load on go, back to erased after write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < fspc_pkg::BLOCK_WORDS; i++) buf_ff[i] <= fspc_pkg::ERASED_WORD;
    end else if (op_done && !is_erase_ff) begin
      for (int i = 0; i < fspc_pkg::BLOCK_WORDS; i++) buf_ff[i] <= fspc_pkg::ERASED_WORD;
    end else if (go_req && !wd[fspc_pkg::CTL_FREE_BIT]) begin
      buf_ff[addr_lo_ff[1:0]] <= {dat_hi_ff, dat_lo_ff};
    end
  end

  // ==========================================================
  // flash array; no reset, cells hold whatever they were given
  // programming only clears bits, so an unerased row corrupts data
  always_ff @(posedge clock) begin
    if (op_done && is_erase_ff) begin
      // [RULE_03] [RULE_04] [RULE_18] [RULE_21] one row only, bits 4:0 ignored
      for (int i = 0; i < fspc_pkg::ROW_WORDS; i++)
        mem[{widx[10:5], 5'(i)}] <= fspc_pkg::ERASED_WORD;
    end else if (op_done) begin
      // [RULE_10] aligned block, never crosses a boundary
      for (int i = 0; i < fspc_pkg::BLOCK_WORDS; i++)
        mem[{widx[10:2], 2'(i)}] <= mem[{widx[10:2], 2'(i)}] & buf_ff[i];
    end
  end

  // ==========================================================
  // outputs
  assign addr_low_reg    = addr_lo_ff;
  assign addr_high_reg   = addr_hi_ff;
  assign data_low_reg    = dat_lo_ff;
  assign data_high_reg   = dat_hi_ff;
  assign mem_control_reg = {pgd_ff, 2'b00, free_ff, err_ff, write_enable_ff, go_ff, rd_ff};
  assign core_ctl.stall  = state_ff == fspc_pkg::ST_BUSY;
  // read and long write give up only the second slot, erase gives up both
  assign core_ctl.ignore = rd_slot || (state_ff == fspc_pkg::ST_PRE
                                       && (is_erase_ff || pre_cnt_ff == 2'd1));

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_rd_slot: assert property ( // RULE_01
    rd_req |=> (!core_ctl.ignore && rd_ff) ##1 core_ctl.ignore ##1 (!core_ctl.ignore && !rd_ff))
    else $error("read slot wrong");
  a_rd_hold: assert property ( // RULE_02
    (!rd_slot && !cpu_wr.data_lo_we) |=> $stable(dat_lo_ff))
    else $error("read data not held");
  a_erase_row: assert property ( // RULE_03
    (op_done && is_erase_ff) |=> mem[{widx[10:5], 5'h1f}] == 14'h3fff)
    else $error("row not erased");
  a_go_keys: assert property ($rose(go_ff) |-> $past(key_ff) == 2'd2) // RULE_19
    else $error("go without unlock");
  a_go_write_enable: assert property ($rose(go_ff) |-> write_enable_ff && pgd_ff) // RULE_20
    else $error("go without write enable");
  a_erase_setup: assert property ( // RULE_07
    (start_op && wd[fspc_pkg::CTL_FREE_BIT]) |=> core_ctl.ignore [*2] ##1 core_ctl.stall)
    else $error("erase setup wrong");
  a_short_clear: assert property (go_short |=> go_ff ##1 !go_ff) // RULE_15
    else $error("short write go not cleared");
  a_long_slots: assert property ( // RULE_16
    (start_op && !wd[fspc_pkg::CTL_FREE_BIT])
    |=> !core_ctl.ignore ##1 core_ctl.ignore ##1 core_ctl.stall)
    else $error("long write slots wrong");
  a_stall_end: assert property (op_done |=> !core_ctl.stall && !go_ff) // RULE_08
    else $error("stall not released");
  a_stall_len: assert property (core_ctl.stall |-> busy_cnt_ff < CNT_W'(OP_CYCLES)) // RULE_08
    else $error("stall overrun");
  a_buf_reset: assert property ( // RULE_17
    (op_done && !is_erase_ff) |=> buf_ff[0] == 14'h3fff && buf_ff[3] == 14'h3fff)
    else $error("buffers not reset");
  a_protect: assert property ((go_req && !go_short && prot) |=> !go_ff && err_ff) // RULE_09
    else $error("protected write started");

  // main scenarios: read, erase, long write, buffer load, refused go
  c_read:   cover property (rd_req ##3 state_ff == fspc_pkg::ST_IDLE);
  c_erase:  cover property (op_done && is_erase_ff);
  c_write:  cover property (op_done && !is_erase_ff);
  c_short:  cover property (go_short ##2 !go_ff);
  c_refuse: cover property (go_req && !go_short && prot);
endmodule : fspc_ctrl

/* tb/fspc_core_model.sv */
// core model: issues self-programming register writes in program order
`timescale 1ns/100ps
module fspc_core_model (
  input  wire logic                        clock,
  input  wire fspc_pkg::fspc_core_ctl_type core_ctl,
  output fspc_pkg::fspc_cpu_wr_type        cpu_wr
);
  logic [5:0] we;
  logic [7:0] wd;
  // strobe order: addr lo, addr hi, data lo, data hi, ctrl, unlock
  assign cpu_wr = {we, wd};
  initial begin
    we = 6'h00;
    wd = 8'h00;
  end
  // ==========================================================
  // one write; a stalled core issues nothing, so wait the stall out
  task automatic wr(input int k, input logic [7:0] v);
    while (core_ctl.stall === 1'b1) @(negedge clock);
    @(negedge clock);
    we = 6'h01 << k;
    wd = v;
    @(negedge clock);
    we = 6'h00;
    wd = ~v; // idle data is not left looking valid
  endtask : wr
  // caller loads address and data first
  task automatic go(input logic [7:0] ctl);
    wr(0, fspc_pkg::UNLOCK_KEY1);
    wr(0, fspc_pkg::UNLOCK_KEY2);
    wr(1, ctl);
  endtask : go
endmodule : fspc_core_model

/* tb/fspc_ctrl_test.sv */
// self-checking bench for the flash self-programming controller
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module fspc_ctrl_test;
  localparam int OPC = 20; // short stall keeps the run brief
  logic                        clock = 1'b0;
  logic                        rst_n;
  logic [1:0]                  write_protect_cfg;
  fspc_pkg::fspc_cpu_wr_type   cpu_wr;
  fspc_pkg::fspc_core_ctl_type core_ctl;
  logic [7:0]                  addr_low_reg;
  logic [7:0]                  addr_high_reg;
  logic [7:0]                  data_low_reg;
  logic [5:0]                  data_high_reg;
  logic [7:0]                  mem_control_reg;
  int                          err_count = 0;
  int                          check_count = 0;
  int                          cyc = 0;
  int                          n;
  fspc_ctrl #(.OP_CYCLES(OPC)) fspc_ctrl_inst (.clock(clock), .rst_n(rst_n),
    .cpu_wr(cpu_wr), .write_protect_cfg(write_protect_cfg), .addr_low_reg(addr_low_reg),
    .addr_high_reg(addr_high_reg), .data_low_reg(data_low_reg),
    .data_high_reg(data_high_reg), .mem_control_reg(mem_control_reg), .core_ctl(core_ctl));
  fspc_core_model fspc_core_model_inst (.clock(clock), .core_ctl(core_ctl), .cpu_wr(cpu_wr));
  // ==========================================================
  // clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end
  // ==========================================================
  // tasks
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic seta(input logic [10:0] a);
    fspc_core_model_inst.wr(4, {5'h00, a[10:8]});
    fspc_core_model_inst.wr(5, a[7:0]);
  endtask : seta
  // slots after go, then stall length and go release
  task automatic walk(input logic ign1);
    `CHK(core_ctl.ignore, ign1)
    @(negedge clock);
    `CHK(core_ctl.ignore, 1'b1)
    n = 0;
    @(negedge clock);
    while (core_ctl.stall === 1'b1 && n < 100) begin
      n++;
      @(negedge clock);
    end
    `CHK(n, OPC)
    `CHK(mem_control_reg[1], 1'b0)
  endtask : walk
  task automatic rdw(input logic [10:0] a, input logic [13:0] e);
    seta(a);
    `CHK({addr_high_reg, addr_low_reg}, {5'h00, a})
    fspc_core_model_inst.wr(1, 8'h81);
    `CHK({core_ctl.ignore, mem_control_reg[0]}, 2'b01)
    @(negedge clock);
    `CHK({core_ctl.ignore, mem_control_reg[0]}, 2'b11)
    @(negedge clock);
    `CHK({core_ctl.ignore, mem_control_reg[0]}, 2'b00)
    `CHK({data_high_reg, data_low_reg}, e)
  endtask : rdw
  task automatic wrw(input logic [10:0] a, input logic [13:0] d);
    seta(a);
    fspc_core_model_inst.wr(3, d[7:0]);
    fspc_core_model_inst.wr(2, {2'b00, d[13:8]});
    fspc_core_model_inst.go(8'h86);
  endtask : wrw
  task automatic refused;
    `CHK(mem_control_reg[1], 1'b0)
    @(negedge clock);
    `CHK(core_ctl.stall, 1'b0)
  endtask : refused
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    write_protect_cfg = 2'b11;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    `CHK({mem_control_reg, data_low_reg, core_ctl}, 18'h00000)
    // erase from an unaligned address, then probe both row ends
    // row erased before any block write
    seta(11'h135);
    fspc_core_model_inst.go(8'h96);
    walk(1'b1);
    rdw(11'h120, 14'h3fff);
    rdw(11'h13f, 14'h3fff);
    // block write: three buffer loads then the programming load
    for (int i = 0; i < 4; i++) begin
      wrw(11'h120 + 11'(i), 14'h1a50 + 14'(i));
      if (i < 3) begin
        `CHK(mem_control_reg[1], 1'b1)
        @(negedge clock);
        `CHK(mem_control_reg[1], 1'b0)
      end else begin
        walk(1'b0);
      end
    end
    for (int i = 0; i < 4; i++) rdw(11'h120 + 11'(i), 14'h1a50 + 14'(i));
    // lone last-word load: stale buffers would leak into the first three
    wrw(11'h127, 14'h2bcd);
    walk(1'b0);
    for (int i = 4; i < 7; i++) rdw(11'h120 + 11'(i), 14'h3fff);
    rdw(11'h127, 14'h2bcd);
    // go refused: no keys, reversed keys, broken keys, write enable clear
    seta(11'h12b);
    fspc_core_model_inst.wr(1, 8'h86);
    refused();
    fspc_core_model_inst.wr(0, 8'haa);
    fspc_core_model_inst.wr(0, 8'h55);
    fspc_core_model_inst.wr(1, 8'h86);
    refused();
    fspc_core_model_inst.wr(0, 8'h55);
    fspc_core_model_inst.wr(3, 8'h00);
    fspc_core_model_inst.wr(0, 8'haa);
    fspc_core_model_inst.wr(1, 8'h86);
    refused();
    fspc_core_model_inst.go(8'h82);
    refused();
    rdw(11'h12b, 14'h3fff);
    // protected modes: zero data would show any write that slipped through
    seta(11'h123);
    fspc_core_model_inst.wr(3, 8'h00);
    fspc_core_model_inst.wr(2, 8'h00);
    for (int c = 0; c < 3; c++) begin
      write_protect_cfg = 2'(c);
      fspc_core_model_inst.go(8'h86);
      `CHK(mem_control_reg[3], 1'b1)
      refused();
      fspc_core_model_inst.wr(1, 8'h80);
      `CHK(mem_control_reg[3], 1'b0)
    end
    write_protect_cfg = 2'b11;
    rdw(11'h123, 14'h1a53);
    end_sim();
  end
endmodule : fspc_ctrl_test
